// >>> sim/lesr_regs_monitor.sv
`timescale 1ns/10ps
// Port checker for the register block
module lesr_mon
(
    input logic aclk,
    input logic aresetn,
    input logic global_reset_n,
    input logic clk_en,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic phy_enhancement_gate,
    input logic [7:0] tx_stream_fmt,
    input lesr_pkg::lesr_enables_t enables,
    input logic tx_stamp_enhance,
    input lesr_pkg::lesr_subsys_t subsys_id,
    input logic subsys_id_load
);
    import lesr_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    // Enhancement outputs follow gate and stream format
    a_enable_gate: assert property (disable iff (!global_reset_n)
        !phy_enhancement_gate |-> enables == '0) else $error("enable without gate");
    a_stamp_mpeg: assert property (disable iff (!global_reset_n)
        clk_en && enables.transport_stream_stamp_on && tx_stream_fmt == LESR_FMT_MPEG
        |=> tx_stamp_enhance) else $error("mpeg stamp missing");
    a_stamp_dv: assert property (disable iff (!global_reset_n)
        clk_en && enables.video_stream_stamp_on && tx_stream_fmt == LESR_FMT_DV
        |=> tx_stamp_enhance) else $error("dv stamp missing");
    a_stamp_off: assert property (disable iff (!global_reset_n)
        clk_en && !phy_enhancement_gate |=> !tx_stamp_enhance) else $error("stamp without gate");
    // Bus answers hold until taken
    a_bresp_hold: assert property (disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ar_refuse: assert property (disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    // Identity change comes with its load pulse
    a_subsys_load: assert property (disable iff (!global_reset_n)
        $changed(subsys_id) && $past(global_reset_n) |-> subsys_id_load)
        else $error("identity load missing");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_stamp: cover property ($rose(tx_stamp_enhance));
endmodule // lesr_mon

// >>> sim/lesr_regs_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the register block
module lesr_regs_tb;
    import lesr_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, global_reset_n = 1'b0, gate = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic preload_valid = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic tx_stamp, prog, prog_v, sub_load;
    logic clk_en = 1'b1;
    logic [3:0] strb = 4'hf, strb_sel, en_exp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, fmt = 8'h00;
    logic [15:0] preload_enh = 16'h0000, p;
    logic [31:0] wdata = 32'h0, rnd = 32'h0, d, rdata;
    logic [1:0] bresp, rresp;
    lesr_enables_t enables;
    lesr_subsys_t subsys_id;
    integer seed = 32'h58a9d259;
    int n_mismatch = 0, checked = 0, cyc = 0, m_enh, m_sub;

    lesr_regs uut (.aclk(aclk), .aresetn(aresetn), .global_reset_n(global_reset_n),
        .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .preload_valid(preload_valid), .preload_enh(preload_enh),
        .phy_enhancement_gate(gate), .tx_stream_fmt(fmt), .enables(enables),
        .tx_stamp_enhance(tx_stamp), .phy_program_gate_load(prog),
        .phy_program_gate_load_valid(prog_v), .subsys_id(subsys_id),
        .subsys_id_load(sub_load));

    always #2.5 aclk = ~aclk;

    // Random gate, format and data; hang guard
    always @(posedge aclk)
    begin
        rnd <= $random(seed);
        gate <= rnd[0];
        fmt <= rnd[1] ? LESR_FMT_MPEG : (rnd[2] ? LESR_FMT_DV : rnd[15:8]);
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Byte lanes that a strobe pattern lets through
    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Write with both channels offered together
    task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                       input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        strb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= rnd[3];
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (!bready) bready <= 1'b1;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
        @(posedge aclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= rnd[4];
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (!rready) rready <= 1'b1;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
        chk("rdata", rdata, e);
        chk("rresp", 32'(rresp), 32'(er));
        @(posedge aclk);
    endtask

    task automatic close_out();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        global_reset_n <= 1'b1;
        @(posedge aclk);
        rdc(LESR_LINK_ENH_OFS, 0, LESR_RESP_OKAY);
        rdc(LESR_SUBSYS_OFS, 0, LESR_RESP_OKAY);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 32'hffff_ffff : rnd;
            strb_sel = (i == 0) ? 4'hf : rnd[19:16];
            m_enh = ((m_enh & ~lanes(strb_sel)) | (d & lanes(strb_sel))) & 32'h0000_0582;
            m_sub = (m_sub & ~lanes(strb_sel)) | (~d & lanes(strb_sel));
            wrc(LESR_LINK_ENH_OFS, d, strb_sel, LESR_RESP_OKAY);
            wrc(LESR_SUBSYS_OFS, ~d, strb_sel, LESR_RESP_OKAY);
            rdc(LESR_LINK_ENH_OFS, m_enh, LESR_RESP_OKAY);
            rdc(LESR_SUBSYS_OFS, m_sub, LESR_RESP_OKAY);
            chk("subsys_id", subsys_id, m_sub);
            en_exp = {m_enh[10], m_enh[8], m_enh[7], m_enh[1]};
            @(negedge aclk);
            chk("enables", 32'(enables), gate ? 32'(en_exp) : 32'h0);
            @(posedge aclk);
        end
        $display("test write_read done");
        wrc(8'hf0, 32'hffff_ffff, 4'hf, LESR_RESP_SLVERR);
        rdc(8'hf0, 0, LESR_RESP_SLVERR);
        rdc(LESR_SUBSYS_OFS, m_sub, LESR_RESP_OKAY);
        $display("test unmapped done");
        p = rnd[15:0];
        preload_enh <= p;
        preload_valid <= 1'b1;
        @(posedge aclk);
        preload_valid <= 1'b0;
        @(negedge aclk);
        chk("prog_gate", 32'(prog), 32'(p[6]));
        chk("prog_valid", 32'(prog_v), 32'h1);
        @(posedge aclk);
        m_enh = {16'h0, p} & 32'h0000_0582;
        rdc(LESR_LINK_ENH_OFS, m_enh, LESR_RESP_OKAY);
        $display("test preload done");
        // Preload under a low clock enable must leave every bit alone
        clk_en <= 1'b0;
        preload_enh <= ~p;
        preload_valid <= 1'b1;
        @(posedge aclk);
        preload_valid <= 1'b0;
        @(negedge aclk);
        chk("frozen_valid", 32'(prog_v), 32'h0);
        @(posedge aclk);
        clk_en <= 1'b1;
        rdc(LESR_LINK_ENH_OFS, m_enh, LESR_RESP_OKAY);
        $display("test freeze done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(LESR_LINK_ENH_OFS, m_enh, LESR_RESP_OKAY);
        rdc(LESR_SUBSYS_OFS, m_sub, LESR_RESP_OKAY);
        global_reset_n <= 1'b0;
        repeat (2) @(posedge aclk);
        global_reset_n <= 1'b1;
        @(posedge aclk);
        rdc(LESR_LINK_ENH_OFS, 0, LESR_RESP_OKAY);
        rdc(LESR_SUBSYS_OFS, 0, LESR_RESP_OKAY);
        $display("test resets done");
        close_out();
    end
endmodule // lesr_regs_tb

bind lesr_regs lesr_mon mon (.aclk(aclk), .aresetn(aresetn),
    .global_reset_n(global_reset_n), .clk_en(clk_en), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .phy_enhancement_gate(phy_enhancement_gate), .tx_stream_fmt(tx_stream_fmt),
    .enables(enables), .tx_stamp_enhance(tx_stamp_enhance), .subsys_id(subsys_id),
    .subsys_id_load(subsys_id_load));

// >>> verilog/lesr_pkg.sv
package lesr_pkg;

    // Register byte addresses
    localparam logic [7:0] LESR_LINK_ENH_OFS = 8'hf4;
    localparam logic [7:0] LESR_SUBSYS_OFS = 8'hf8;
    localparam logic [7:0] LESR_HCCTL_OFS = 8'h50;

    // Link enhancement field positions
    localparam int LESR_TS_MPEG_BIT = 10;
    localparam int LESR_TS_DV_BIT = 8;
    localparam int LESR_PRIO_BIT = 7;
    localparam int LESR_UNASSIGNED_BIT = 6;
    localparam int LESR_RSVD2_BIT = 2;
    localparam int LESR_ACCEL_BIT = 1;

    // Host controller control field positions
    localparam int LESR_PHY_ENH_BIT = 22;
    localparam int LESR_PHY_PROG_BIT = 23;

    // Stream format codes
    localparam logic [7:0] LESR_FMT_MPEG = 8'h20;
    localparam logic [7:0] LESR_FMT_DV = 8'h00;

    // Reset values
    localparam logic [31:0] LESR_SUBSYS_RST = 32'h0000_0000;
    localparam logic LESR_ENABLE_RST = 1'b0;

    // AXI response codes
    localparam logic [1:0] LESR_RESP_OKAY = 2'h0;
    localparam logic [1:0] LESR_RESP_SLVERR = 2'h2;

    // Function-level enables seen by the link datapaths
    typedef struct packed {
        logic transport_stream_stamp_on;
        logic video_stream_stamp_on;
        logic priority_request_on;
        logic accel_notify_on;
    } lesr_enables_t;

    // Subsystem identity pair
    typedef struct packed {
        logic [15:0] subsystem_device_alias;
        logic [15:0] subsystem_vendor_alias;
    } lesr_subsys_t;

endpackage

// >>> verilog/lesr_regs.sv
`timescale 1ns/10ps
// What this block does
// - Bit 10 set turns on the timestamp enhancement for transmit streams of format 20h.
// - Bit 8 set turns on the timestamp enhancement for transmit streams of format 00h.
// - Bit 7 set makes the link answer asynchronous requests with priority arbitration.
// - Bit 1 set tells the PHY that the link supports the acceleration enhancements.
// - The four enable bits come out of reset as zero.
// - Bits 11, 9, 5 to 3, 2 and 0 of the link enhancement word read as zero.
// - Bit 6 reads zero; its load from the enhancement preload goes to the PHY program gate.
// - Enable bits 10, 8, 7 and 1 are cleared only by the global reset; bit 2 has no storage.
// - A write to the subsystem word also loads the function's subsystem identity.
// - A read of the subsystem word returns the value last written.
// - Subsystem word holds device alias in 31:16 and vendor alias in 15:0, global reset only.
// - An enhancement acts only while the PHY enhancement gate is also set.
module lesr_regs
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic global_reset_n,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Preload from the serial EEPROM
    input wire logic preload_valid,
    input wire logic [15:0] preload_enh,
    // Host controller control gates and stream format of the current packet
    input wire logic phy_enhancement_gate,
    input wire logic [7:0] tx_stream_fmt,
    // Block outputs
    output lesr_pkg::lesr_enables_t enables,
    output logic tx_stamp_enhance,
    output logic phy_program_gate_load,
    output logic phy_program_gate_load_valid,
    output lesr_pkg::lesr_subsys_t subsys_id,
    output logic subsys_id_load
);
    import lesr_pkg::*;

    // Bus state
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic aw_have_r, aw_have_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic w_have_r, w_have_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Register state
    logic mpeg_r, mpeg_nxt;
    logic dv_r, dv_nxt;
    logic prio_r, prio_nxt;
    logic accel_r, accel_nxt;
    lesr_subsys_t subsys_r, subsys_nxt;
    logic subsys_load_r, subsys_load_nxt;
    logic prog_r, prog_nxt;
    logic prog_v_r, prog_v_nxt;
    logic stamp_r, stamp_nxt;
    logic do_write;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lesr_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Link enhancement word as read back
    function automatic logic [31:0] lesr_enh_word(input logic m, input logic d, input logic p,
                                                  input logic a);
        logic [31:0] res;
        // Bit 2 has no storage, so it reads zero with the others
        res = 32'h0000_0000;
        res[LESR_TS_MPEG_BIT] = m;
        res[LESR_TS_DV_BIT] = d;
        res[LESR_PRIO_BIT] = p;
        res[LESR_ACCEL_BIT] = a;
        return res;
    endfunction

    // A write applies once both halves are held and the last answer is gone
    assign do_write = aw_have_r && w_have_r && !bvalid_r;
    // Readies fall while frozen, so no address or data is lost
    assign s_axi_awready = !aw_have_r && clk_en;
    assign s_axi_wready = !w_have_r && clk_en;
    assign s_axi_arready = !rvalid_r && clk_en;

    // Write and read channel next state
    always_comb
    begin
        aw_addr_nxt = aw_addr_r;
        aw_have_nxt = aw_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && !aw_have_r)
        begin
            aw_addr_nxt = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && !w_have_r)
        begin
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
            w_have_nxt = 1'b1;
        end
        if (do_write)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_addr_r[7:2] == LESR_LINK_ENH_OFS[7:2] ||
                         aw_addr_r[7:2] == LESR_SUBSYS_OFS[7:2]) ? LESR_RESP_OKAY
                                                                 : LESR_RESP_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = LESR_RESP_OKAY;
            if (s_axi_araddr[7:2] == LESR_LINK_ENH_OFS[7:2])
            begin
                rdata_nxt = lesr_enh_word(mpeg_r, dv_r, prio_r, accel_r);
            end
            else if (s_axi_araddr[7:2] == LESR_SUBSYS_OFS[7:2])
            begin
                rdata_nxt = subsys_r;
            end
            else
            begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = LESR_RESP_SLVERR;
            end
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    // Bus state registers, bus reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_r <= 8'h00;
            aw_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= LESR_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= LESR_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            aw_addr_r <= aw_addr_nxt;
            aw_have_r <= aw_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            w_have_r <= w_have_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Register file next state
    always_comb
    begin
        logic [31:0] merged;
        merged = 32'h0000_0000;
        mpeg_nxt = mpeg_r;
        dv_nxt = dv_r;
        prio_nxt = prio_r;
        accel_nxt = accel_r;
        subsys_nxt = subsys_r;
        subsys_load_nxt = 1'b0;
        prog_nxt = prog_r;
        prog_v_nxt = 1'b0;
        // A bus write to either mapped word wins over a preload in the same cycle
        if (do_write && aw_addr_r[7:2] == LESR_LINK_ENH_OFS[7:2])
        begin
            merged = lesr_merge(lesr_enh_word(mpeg_r, dv_r, prio_r, accel_r), w_data_r, w_strb_r);
            // Only writable positions are taken
            mpeg_nxt = merged[LESR_TS_MPEG_BIT];
            dv_nxt = merged[LESR_TS_DV_BIT];
            prio_nxt = merged[LESR_PRIO_BIT];
            accel_nxt = merged[LESR_ACCEL_BIT];
        end
        else if (do_write && aw_addr_r[7:2] == LESR_SUBSYS_OFS[7:2])
        begin
            subsys_nxt = lesr_merge(subsys_r, w_data_r, w_strb_r);
            subsys_load_nxt = 1'b1;
        end
        else if (preload_valid)
        begin
            // EEPROM preload of enhancement bits
            mpeg_nxt = preload_enh[LESR_TS_MPEG_BIT];
            dv_nxt = preload_enh[LESR_TS_DV_BIT];
            prio_nxt = preload_enh[LESR_PRIO_BIT];
            accel_nxt = preload_enh[LESR_ACCEL_BIT];
            prog_nxt = preload_enh[LESR_UNASSIGNED_BIT];
            prog_v_nxt = 1'b1;
        end
    end

    // Stamp select by stream format, gated by the PHY enhancement gate
    // Other format codes leave the stamp off
    always_comb
    begin
        stamp_nxt = phy_enhancement_gate &&
                    ((mpeg_r && tx_stream_fmt == LESR_FMT_MPEG) ||
                     (dv_r && tx_stream_fmt == LESR_FMT_DV));
    end

    // Register file, global reset only
    // A bus reset leaves these contents alone
    always_ff @(posedge aclk)
    begin
        if (!global_reset_n)
        begin
            mpeg_r <= LESR_ENABLE_RST;
            dv_r <= LESR_ENABLE_RST;
            prio_r <= LESR_ENABLE_RST;
            accel_r <= LESR_ENABLE_RST;
            subsys_r <= LESR_SUBSYS_RST;
            subsys_load_r <= 1'b0;
            prog_r <= 1'b0;
            prog_v_r <= 1'b0;
            stamp_r <= 1'b0;
        end
        else if (clk_en)
        begin
            mpeg_r <= mpeg_nxt;
            dv_r <= dv_nxt;
            prio_r <= prio_nxt;
            accel_r <= accel_nxt;
            subsys_r <= subsys_nxt;
            subsys_load_r <= subsys_load_nxt;
            prog_r <= prog_nxt;
            prog_v_r <= prog_v_nxt;
            stamp_r <= stamp_nxt;
        end
    end

    // Outputs
    // A response taken while frozen is offered again; keep clk_en high then
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign enables = {mpeg_r, dv_r, prio_r, accel_r}
                     & {4{phy_enhancement_gate}};
    assign tx_stamp_enhance = stamp_r;
    assign phy_program_gate_load = prog_r;
    assign phy_program_gate_load_valid = prog_v_r;
    assign subsys_id = subsys_r;
    assign subsys_id_load = subsys_load_r;

endmodule // lesr_regs
